// [verilog/aic_input_cond.sv]
// analog and binary input conditioning with register port and interrupt
`timescale 1ns/1ps
`include "aic_map.svh"

module aic_input_cond
#(
  parameter int TICK_CYCLES = `AIC_TICK_NS / `AIC_CLK_PERIOD_NS
)
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // analog sample, same clock domain
  input wire logic signed [15:0] analog_sample,
  input wire logic analog_valid,
  // binary input pins
  input wire logic [6:0] binary_input,
  // conditioned results
  output logic wire_break_alarm,
  output logic [6:0] binary_active,
  output logic lock_monitor_alarm,
  output logic external_ack,
  output logic system_b_breaker_open,
  output logic signed [15:0] display_value,
  output logic [23:0] display_digits,
  output logic irq
);

  localparam int NI = `AIC_NUM_INPUTS;

  // configuration
  aic_pkg::aic_wb_mode_type mode_reg;
  logic self_ack_reg;
  logic [2:0] filt_reg;
  logic [2:0] digits_reg;
  logic [6:0] pol_reg;
  logic signed [15:0] min_reg;
  logic signed [15:0] max_reg;
  logic [15:0] delay_reg [NI];
  logic [7:0] irq_stat_reg;
  logic [7:0] irq_mask_reg;

  // datapath state
  logic [18:0] tick_cnt_reg;
  logic tick_reg;
  logic filt_tick_reg;
  logic signed [15:0] sample_reg;
  logic signed [23:0] acc_reg;
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  logic [15:0] cnt_reg [NI];
  logic [23:0] fmt_digits;

  logic [6:0] cond_level;
  logic [6:0] act_next;
  logic brk;
  logic self_ack_eff;
  logic man_ack;
  logic wr_ctrl;
  logic [7:0] irq_events;

  function automatic logic aic_brk(input aic_pkg::aic_wb_mode_type m,
    input logic signed [15:0] x, input logic signed [15:0] lo,
    input logic signed [15:0] hi);
    logic over;
    logic under;
    over = x > hi;
    under = x < lo;
    unique case (m)
      aic_pkg::AIC_WB_OFF: aic_brk = 1'b0;
      aic_pkg::AIC_WB_HIGH: aic_brk = over;
      aic_pkg::AIC_WB_LOW: aic_brk = under;
      aic_pkg::AIC_WB_HIGH_LOW: aic_brk = over | under;
    endcase
  endfunction

  function automatic logic signed [23:0] aic_filt_step(
    input logic signed [23:0] acc, input logic signed [15:0] x,
    input logic [2:0] n);
    logic signed [24:0] diff;
    logic signed [24:0] step;
    // sign-extend the scaled sample, a plain concat would be unsigned
    diff = 25'($signed({x, 8'h00})) - 25'(acc);
    step = diff >>> (n - 3'h1);
    aic_filt_step = acc + step[23:0];
  endfunction

  assign brk = aic_brk(mode_reg, sample_reg, min_reg, max_reg);
  assign self_ack_eff = self_ack_reg && (mode_reg != aic_pkg::AIC_WB_OFF);
  assign man_ack = reg_wr && reg_addr == `AIC_OFS_ACK && reg_wdata[0];
  assign wr_ctrl = reg_wr && reg_addr == `AIC_OFS_CTRL;
  assign cond_level = sync2_reg ^ pol_reg;

  always_comb
  begin
    for (int i = 0; i < NI; i++)
      act_next[i] = cond_level[i] && cnt_reg[i] >= delay_reg[i];
  end

  assign irq_events = {act_next & ~binary_active,
    brk & ~wire_break_alarm};

  assign lock_monitor_alarm = binary_active[0];
  assign external_ack = binary_active[1];
  assign system_b_breaker_open = binary_active[2];
  assign display_digits = fmt_digits;

  // configuration registers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_reg <= aic_pkg::AIC_WB_OFF;
      self_ack_reg <= 1'b0;
      filt_reg <= `AIC_RST_FILT;
      digits_reg <= `AIC_RST_DIGITS;
      pol_reg <= 7'h00;
      min_reg <= `AIC_RST_RANGE_MIN;
      max_reg <= `AIC_RST_RANGE_MAX;
      irq_mask_reg <= 8'h00;
      for (int i = 0; i < NI; i++)
        delay_reg[i] <= (i == 0 || i == 3) ? `AIC_RST_DELAY_SHORT
                                           : `AIC_RST_DELAY_LONG;
    end
    else if (clk_en && reg_wr)
    begin
      if (wr_ctrl)
      begin
        mode_reg <= aic_pkg::aic_wb_mode_type'(
          reg_wdata[`AIC_CTRL_MODE_LSB +: 2]);
        self_ack_reg <= reg_wdata[`AIC_CTRL_SELF_ACK];
        // settings above 5 are not a valid filter step
        if (reg_wdata[`AIC_CTRL_FILT_LSB +: 3] <= 3'h5)
          filt_reg <= reg_wdata[`AIC_CTRL_FILT_LSB +: 3];
        digits_reg <= reg_wdata[`AIC_CTRL_DIGITS_LSB +: 3];
      end
      if (reg_addr == `AIC_OFS_POLARITY)
        pol_reg <= reg_wdata[6:0];
      if (reg_addr == `AIC_OFS_RANGE_MIN)
        min_reg <= reg_wdata[15:0];
      if (reg_addr == `AIC_OFS_RANGE_MAX)
        max_reg <= reg_wdata[15:0];
      if (reg_addr == `AIC_OFS_IRQ_MASK)
        irq_mask_reg <= reg_wdata[7:0];
      for (int i = 0; i < NI; i++)
      begin
        // delays below the shortest legal setting are raised to it
        if (reg_addr == 8'(`AIC_OFS_DELAY0 + 4 * i))
          delay_reg[i] <= (reg_wdata[15:0] < `AIC_DELAY_MIN) ?
            `AIC_DELAY_MIN : reg_wdata[15:0];
      end
    end
  end

  // 10 ms tick and 20 ms filter tick
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tick_cnt_reg <= 19'h0_0000;
      tick_reg <= 1'b0;
      filt_tick_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      tick_reg <= tick_cnt_reg == 19'(TICK_CYCLES - 1);
      if (tick_cnt_reg == 19'(TICK_CYCLES - 1))
        tick_cnt_reg <= 19'h0_0000;
      else
        tick_cnt_reg <= tick_cnt_reg + 19'h0_0001;
      if (tick_reg)
        filt_tick_reg <= ~filt_tick_reg;
    end
  end

  // analog path
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sample_reg <= 16'sh0000;
      acc_reg <= 24'sh00_0000;
      display_value <= 16'sh0000;
    end
    else if (clk_en)
    begin
      if (analog_valid)
        sample_reg <= analog_sample;
      if (filt_reg == 3'h0)
        acc_reg <= {sample_reg, 8'h00};
      else if (tick_reg && filt_tick_reg)
        acc_reg <= aic_filt_step(acc_reg, sample_reg, filt_reg);
      display_value <= acc_reg[23:8];
    end
  end

  // wire-break alarm latch; a new break wins over any clear
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      wire_break_alarm <= 1'b0;
    else if (clk_en)
    begin
      if (mode_reg == aic_pkg::AIC_WB_OFF)
        wire_break_alarm <= 1'b0;
      else if (brk)
        wire_break_alarm <= 1'b1;
      else if (self_ack_eff)
        wire_break_alarm <= 1'b0;
      else if (man_ack || binary_active[1])
        wire_break_alarm <= 1'b0;
    end
  end

  // binary inputs: pins cross in through two flops
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1_reg <= 7'h00;
      sync2_reg <= 7'h00;
      binary_active <= 7'h00;
      for (int i = 0; i < NI; i++)
        cnt_reg[i] <= 16'h0000;
    end
    else if (clk_en)
    begin
      sync1_reg <= binary_input;
      sync2_reg <= sync1_reg;
      binary_active <= act_next;
      for (int i = 0; i < NI; i++)
      begin
        if (!cond_level[i])
          cnt_reg[i] <= 16'h0000;
        else if (tick_reg && cnt_reg[i] < delay_reg[i])
          cnt_reg[i] <= cnt_reg[i] + 16'h0001;
      end
    end
  end

  // interrupt status, write one to clear, set wins
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_stat_reg <= 8'h00;
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      if (reg_wr && reg_addr == `AIC_OFS_IRQ_STAT)
        irq_stat_reg <= (irq_stat_reg & ~reg_wdata[7:0]) | irq_events;
      else
        irq_stat_reg <= irq_stat_reg | irq_events;
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= 32'h0000_0000;
    else if (clk_en)
    begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd)
      begin
        unique case (reg_addr)
          `AIC_OFS_CTRL: reg_rdata <= 32'({digits_reg, filt_reg,
            self_ack_reg, mode_reg});
          `AIC_OFS_POLARITY: reg_rdata <= 32'(pol_reg);
          `AIC_OFS_RANGE_MIN: reg_rdata <= 32'($unsigned(min_reg));
          `AIC_OFS_RANGE_MAX: reg_rdata <= 32'($unsigned(max_reg));
          `AIC_OFS_STATUS: reg_rdata <= 32'({binary_active, brk,
            wire_break_alarm});
          `AIC_OFS_FILTERED: reg_rdata <= 32'($unsigned(display_value));
          `AIC_OFS_DISPLAY: reg_rdata <= 32'(fmt_digits);
          `AIC_OFS_IRQ_STAT: reg_rdata <= 32'(irq_stat_reg);
          `AIC_OFS_IRQ_MASK: reg_rdata <= 32'(irq_mask_reg);
          default:
          begin
            if (reg_addr >= `AIC_OFS_DELAY0 && reg_addr <= `AIC_OFS_DELAY6
                && reg_addr[1:0] == 2'h0)
              reg_rdata <= 32'(delay_reg[3'(reg_addr[4:2])]);
          end
        endcase
      end
    end
  end

  // display refresh once per filter period
  aic_digit_fmt u_fmt
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .start(tick_reg && filt_tick_reg),
    .value(display_value),
    .num_digits(digits_reg),
    .digits(fmt_digits),
    .done()
  );

  default clocking main_cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_self_ack_clear: assert property (clk_en && wire_break_alarm
    && self_ack_eff && !brk |=> !wire_break_alarm)
    else $error("self-acknowledge did not clear the alarm");

  a_latch_hold: assert property (clk_en && wire_break_alarm
    && !self_ack_reg && !man_ack && !binary_active[1]
    && mode_reg != aic_pkg::AIC_WB_OFF && !wr_ctrl |=> wire_break_alarm)
    else $error("latched alarm cleared without acknowledge");

  a_mode_off_gate: assert property (clk_en
    && mode_reg == aic_pkg::AIC_WB_OFF |=> !wire_break_alarm)
    else $error("alarm present with monitoring off");

  a_filter_off: assert property (clk_en && filt_reg == 3'h0
    && $past(clk_en) && $past(filt_reg) == 3'h0
    |=> display_value == $past(sample_reg, 2))
    else $error("unfiltered path not forwarding the reading");

  a_filter_direction: assert property (clk_en && tick_reg
    && filt_tick_reg && filt_reg != 3'h0 && !wr_ctrl
    && $signed({sample_reg, 8'h00}) >= acc_reg
    |=> acc_reg >= $past(acc_reg))
    else $error("filter moved away from the input");

  a_filter_step: assert property (clk_en && tick_reg && filt_tick_reg
    && filt_reg == 3'h1 && !wr_ctrl |=> acc_reg == {$past(sample_reg), 8'h00})
    else $error("setting one does not follow the sample");

  a_high_break: assert property (clk_en
    && mode_reg == aic_pkg::AIC_WB_HIGH && sample_reg > max_reg
    && !wr_ctrl |=> wire_break_alarm)
    else $error("overshoot did not raise the alarm");

  a_delay_elapsed: assert property ($rose(binary_active[0])
    |-> $past(cnt_reg[0]) >= $past(delay_reg[0]) && $past(cond_level[0]))
    else $error("input active before its delay");

  a_restart_count: assert property (clk_en && !cond_level[2]
    |=> cnt_reg[2] == 16'h0000)
    else $error("delay counter not restarted");

  a_closed_polarity: assert property (clk_en && pol_reg[3]
    && sync2_reg[3] |=> !binary_active[3])
    else $error("energised normally closed input reported active");

  a_open_polarity: assert property (clk_en && !pol_reg[4]
    && !sync2_reg[4] |=> !binary_active[4])
    else $error("idle normally open input reported active");

  a_ext_ack: assert property (clk_en && binary_active[1]
    && mode_reg != aic_pkg::AIC_WB_OFF && !brk |=> !wire_break_alarm)
    else $error("second input did not acknowledge the alarm");

endmodule // aic_input_cond

// [common/aic_map.svh]
// offsets, field positions, reset values and timing counts of the block
`ifndef AIC_MAP_SVH
`define AIC_MAP_SVH

// register byte offsets
`define AIC_OFS_CTRL 8'h00
`define AIC_OFS_POLARITY 8'h04
`define AIC_OFS_RANGE_MIN 8'h08
`define AIC_OFS_RANGE_MAX 8'h0C
`define AIC_OFS_ACK 8'h10
`define AIC_OFS_STATUS 8'h14
`define AIC_OFS_FILTERED 8'h18
`define AIC_OFS_DISPLAY 8'h1C
`define AIC_OFS_IRQ_STAT 8'h20
`define AIC_OFS_IRQ_MASK 8'h24
`define AIC_OFS_DELAY0 8'h40
`define AIC_OFS_DELAY6 8'h58

// control register fields
`define AIC_CTRL_MODE_LSB 0
`define AIC_CTRL_SELF_ACK 2
`define AIC_CTRL_FILT_LSB 3
`define AIC_CTRL_DIGITS_LSB 6

// reset values and the delay minimum
`define AIC_RST_FILT 3'h3
`define AIC_RST_DIGITS 3'h4
`define AIC_RST_RANGE_MIN 16'h0000
`define AIC_RST_RANGE_MAX 16'h7FFF
`define AIC_RST_DELAY_SHORT 16'h0014
`define AIC_RST_DELAY_LONG 16'h0032
`define AIC_DELAY_MIN 16'h0008

// timing: delays count in 10 ms ticks, the filter samples every 20 ms
`define AIC_CLK_PERIOD_NS 25
`define AIC_TICK_NS 10000000
`define AIC_FILT_PERIOD_NS 20000000
`define AIC_FILT_TICKS (`AIC_FILT_PERIOD_NS / `AIC_TICK_NS)

// display digit codes, digit count and input count
`define AIC_CODE_MINUS 4'hA
`define AIC_CODE_BLANK 4'hF
`define AIC_NUM_DIGITS 6
`define AIC_NUM_INPUTS 7

`endif

// [common/aic_pkg.sv]
// types shared by the conditioning block and its display formatter
package aic_pkg;

  typedef enum logic [1:0]
  {
    AIC_WB_OFF = 2'h0,
    AIC_WB_HIGH = 2'h1,
    AIC_WB_LOW = 2'h2,
    AIC_WB_HIGH_LOW = 2'h3
  } aic_wb_mode_type;

  typedef enum logic [2:0]
  {
    AIC_FMT_IDLE = 3'b001,
    AIC_FMT_CONV = 3'b010,
    AIC_FMT_PLACE = 3'b100
  } aic_fmt_state_type;

endpackage

// [verilog/aic_digit_fmt.sv]
// fixed-digit display formatter for the conditioned value
`timescale 1ns/1ps
`include "aic_map.svh"

module aic_digit_fmt
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // value in
  input wire logic start,
  input wire logic signed [15:0] value,
  input wire logic [2:0] num_digits,
  // digits out, position 0 rightmost
  output logic [23:0] digits,
  output logic done
);

  aic_pkg::aic_fmt_state_type state_reg;
  logic [16:0] mag_reg;
  logic neg_reg;
  logic [2:0] pos_reg;
  logic [23:0] work_reg;
  logic [2:0] ndig_reg;
  logic [3:0] lead_pos;
  logic [3:0] nd_eff;

  always_comb
  begin
    nd_eff = (ndig_reg == 3'h0) ? 4'h1 :
      ((ndig_reg > 3'h6) ? 4'h6 : {1'b0, ndig_reg});
    lead_pos = nd_eff - 4'h1;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= aic_pkg::AIC_FMT_IDLE;
      mag_reg <= 17'h0_0000;
      neg_reg <= 1'b0;
      pos_reg <= 3'h0;
      work_reg <= 24'h00_0000;
      ndig_reg <= 3'h1;
      digits <= {`AIC_NUM_DIGITS{`AIC_CODE_BLANK}};
      done <= 1'b0;
    end
    else if (clk_en)
    begin
      done <= 1'b0;
      unique case (state_reg)
        aic_pkg::AIC_FMT_IDLE:
        begin
          if (start)
          begin
            neg_reg <= value[15];
            mag_reg <= value[15] ? 17'(-{value[15], value})
                                 : {1'b0, value};
            ndig_reg <= num_digits;
            pos_reg <= 3'h0;
            work_reg <= {`AIC_NUM_DIGITS{`AIC_CODE_BLANK}};
            state_reg <= aic_pkg::AIC_FMT_CONV;
          end
        end
        aic_pkg::AIC_FMT_CONV:
        begin
          // leading zeros blanked, but the ones digit always shows
          if (mag_reg != 17'h0_0000 || pos_reg == 3'h0)
            work_reg[pos_reg*4 +: 4] <= 4'(mag_reg % 17'd10);
          mag_reg <= mag_reg / 17'd10;
          pos_reg <= pos_reg + 3'h1;
          if (pos_reg == 3'(`AIC_NUM_DIGITS - 1))
            state_reg <= aic_pkg::AIC_FMT_PLACE;
        end
        aic_pkg::AIC_FMT_PLACE:
        begin
          for (int i = 0; i < `AIC_NUM_DIGITS; i++)
          begin
            if (4'(i) > lead_pos)
              digits[i*4 +: 4] <= `AIC_CODE_BLANK;
            else if (neg_reg && 4'(i) == lead_pos)
              digits[i*4 +: 4] <= `AIC_CODE_MINUS;
            else
              digits[i*4 +: 4] <= work_reg[i*4 +: 4];
          end
          done <= 1'b1;
          state_reg <= aic_pkg::AIC_FMT_IDLE;
        end
      endcase
    end
  end

  default clocking fmt_cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_minus_place: assert property (done && neg_reg |->
    digits[lead_pos*4 +: 4] == `AIC_CODE_MINUS)
    else $error("minus sign not in leftmost digit");

  a_right_fill: assert property (done && (!neg_reg || nd_eff > 4'h1) |->
    digits[3:0] == work_reg[3:0] && work_reg[3:0] != `AIC_CODE_BLANK)
    else $error("ones digit not in rightmost position");

endmodule // aic_digit_fmt

// [tb/aic_src_model.sv]
// field signal sources: analog reading and binary input pins
`timescale 1ns/1ps

module aic_src_model
(
  // clock
  input wire logic clk,
  // field side
  output logic signed [15:0] analog_sample,
  output logic analog_valid,
  output logic [6:0] binary_input
);
  initial
  begin
    analog_sample = 16'sh0000;
    analog_valid = 1'b0;
    binary_input = 7'h00;
  end

  // one strobed reading; the line shows junk once released
  task automatic send(input logic signed [15:0] v);
    @(posedge clk);
    analog_sample <= v;
    analog_valid <= 1'b1;
    @(posedge clk);
    analog_valid <= 1'b0;
    analog_sample <= ~v;
  endtask

  task automatic pins(input logic [6:0] p);
    @(posedge clk);
    binary_input <= p;
  endtask
endmodule // aic_src_model

// [tb/tb_top.sv]
// self-checking bench for the input conditioning block
`timescale 1ns/1ps

module tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic signed [15:0] analog_sample;
  logic analog_valid;
  logic [6:0] binary_input;
  logic wire_break_alarm;
  logic [6:0] binary_active;
  logic lock_monitor_alarm;
  logic external_ack;
  logic system_b_breaker_open;
  logic signed [15:0] display_value;
  logic [23:0] display_digits;
  logic irq;
  logic [31:0] rv;
  int miscompares = 0;
  int n_compared = 0;

  always #12.5 clk = ~clk;

  aic_input_cond #(.TICK_CYCLES(4)) aic_input_cond_i
  (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .analog_sample(analog_sample), .analog_valid(analog_valid),
    .binary_input(binary_input), .wire_break_alarm(wire_break_alarm),
    .binary_active(binary_active), .lock_monitor_alarm(lock_monitor_alarm),
    .external_ack(external_ack),
    .system_b_breaker_open(system_b_breaker_open),
    .display_value(display_value), .display_digits(display_digits),
    .irq(irq)
  );

  aic_src_model aic_src_model_i
  (
    .clk(clk), .analog_sample(analog_sample),
    .analog_valid(analog_valid), .binary_input(binary_input)
  );

  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] e,
    input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // bounded wait on one watched output
  task automatic wait_on(input int w, input logic v, input int bound);
    logic s;
    for (int i = 0; i < bound; i++)
    begin
      @(posedge clk);
      #1;
      s = (w == 0) ? wire_break_alarm : (w == 1) ? irq :
        (w == 2) ? lock_monitor_alarm : binary_active[3];
      if (s === v)
        return;
    end
    miscompares++;
    $display("BAD wait %0d expected %b seen timeout", w, v);
    finish_test();
  endtask

  task automatic t_reset_values();
    rd(8'h00, rv);
    chk("ctrl", 32'h0000_0118, rv);
    rd(8'h0C, rv);
    chk("range_max", 32'h0000_7FFF, rv);
    rd(8'h40, rv);
    chk("delay0", 32'h0000_0014, rv);
    rd(8'h44, rv);
    chk("delay1", 32'h0000_0032, rv);
    rd(8'h30, rv);
    chk("unmapped", 32'h0000_0000, rv);
    wr(8'h00, 32'h0000_0130);
    rd(8'h00, rv);
    chk("filter6", 32'h0000_0118, rv);
  endtask

  task automatic t_latched_alarm();
    wr(8'h0C, 32'h0000_03E8);
    wr(8'h00, 32'h0000_0101);
    wr(8'h24, 32'h0000_0001);
    aic_src_model_i.send(16'sd2000);
    wait_on(0, 1'b1, 4);
    wait_on(1, 1'b1, 3);
    aic_src_model_i.send(16'sd500);
    repeat (6) @(posedge clk);
    #1;
    chk("held", 32'h1, {31'h0, wire_break_alarm});
    wr(8'h10, 32'h0000_0001);
    wait_on(0, 1'b0, 3);
    wr(8'h20, 32'h0000_0001);
    wait_on(1, 1'b0, 3);
  endtask

  task automatic t_self_ack();
    wr(8'h00, 32'h0000_0106);
    aic_src_model_i.send(-16'sd5);
    wait_on(0, 1'b1, 4);
    aic_src_model_i.send(16'sd10);
    wait_on(0, 1'b0, 4);
    wr(8'h00, 32'h0000_0107);
    aic_src_model_i.send(16'sd2000);
    wait_on(0, 1'b1, 4);
    aic_src_model_i.send(-16'sd5);
    repeat (4) @(posedge clk);
    #1;
    chk("still", 32'h1, {31'h0, wire_break_alarm});
    wr(8'h00, 32'h0000_0104);
    aic_src_model_i.send(16'sd2000);
    repeat (6) @(posedge clk);
    #1;
    chk("mode_off", 32'h0, {31'h0, wire_break_alarm});
    wr(8'h20, 32'h0000_0001);
  endtask

  task automatic t_display();
    wr(8'h00, 32'h0000_00C0);
    aic_src_model_i.send(16'sd1234);
    repeat (4) @(posedge clk);
    #1;
    chk("raw", 32'd1234, {16'h0, display_value});
    repeat (40) @(posedge clk);
    #1;
    chk("digits3", 32'h00FF_F234, {8'h0, display_digits});
    wr(8'h00, 32'h0000_0100);
    aic_src_model_i.send(-16'sd12);
    repeat (44) @(posedge clk);
    #1;
    chk("minus", 32'h00FF_AF12, {8'h0, display_digits});
  endtask

  task automatic t_filter();
    logic [15:0] first;
    for (int n = 1; n <= 5; n++)
    begin
      wr(8'h00, 32'h0000_0100);
      aic_src_model_i.send(16'sd0);
      repeat (4) @(posedge clk);
      wr(8'h00, 32'h0000_0100 | (n << 3));
      aic_src_model_i.send(16'sd1000);
      first = 16'h0;
      for (int i = 0; i < 40 && first == 16'h0; i++)
      begin
        @(posedge clk);
        #1;
        first = display_value;
      end
      chk("step", (256000 >> (n - 1)) >> 8, {16'h0, first});
    end
  endtask

  task automatic t_binary();
    wr(8'h00, 32'h0000_0101);
    aic_src_model_i.send(16'sd2000);
    aic_src_model_i.send(16'sd500);
    wr(8'h20, 32'h0000_00FF);
    wr(8'h40, 32'h0000_0008);
    wr(8'h44, 32'h0000_0003);
    wr(8'h48, 32'h0000_0008);
    rd(8'h44, rv);
    chk("delay_min", 32'h0000_0008, rv);
    aic_src_model_i.pins(7'h07);
    repeat (24) @(posedge clk);
    chk("early", 32'h0, {25'h0, binary_active});
    aic_src_model_i.pins(7'h00);
    repeat (4) @(posedge clk);
    aic_src_model_i.pins(7'h07);
    repeat (24) @(posedge clk);
    chk("restart", 32'h0, {25'h0, binary_active});
    wait_on(2, 1'b1, 30);
    #1;
    chk("defaults", 32'h7, {29'h0, system_b_breaker_open, external_ack,
      lock_monitor_alarm});
    // the acknowledge acts one edge after the input turns active
    @(posedge clk);
    #1;
    chk("ext_ack", 32'h0, {31'h0, wire_break_alarm});
    wr(8'h04, 32'h0000_0008);
    wait_on(3, 1'b1, 120);
    aic_src_model_i.pins(7'h0F);
    wait_on(3, 1'b0, 6);
    rd(8'h20, rv);
    // break event was cleared before the inputs rose
    chk("irq_stat", 32'h0000_001E, rv);
  endtask

  // strobes and samples are lost while the enable is low
  task automatic t_freeze();
    @(posedge clk);
    clk_en <= 1'b0;
    wr(8'h24, 32'h0000_00FE);
    aic_src_model_i.send(16'sd300);
    repeat (8) @(posedge clk);
    #1;
    chk("frozen", 32'd500, {16'h0, display_value});
    @(posedge clk);
    clk_en <= 1'b1;
    rd(8'h24, rv);
    chk("mask_kept", 32'h0000_0001, rv);
    repeat (4) @(posedge clk);
    #1;
    chk("thawed", 32'd500, {16'h0, display_value});
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset_values();
    t_latched_alarm();
    t_self_ack();
    t_display();
    t_filter();
    t_binary();
    t_freeze();
    finish_test();
  end
endmodule // tb_top
